// *** verilog/ric_pkg.sv ***
package ric_pkg;
	// ---------------------------------------------------------------
	// Vector pairs, low byte of each pair
	// ---------------------------------------------------------------
	localparam logic [15:0] RESET_VEC = 16'h7FFE;
	localparam logic [15:0] TRAP_VEC  = 16'h7FFC;
	localparam logic [15:0] EXT_VEC   = 16'h7FFA;
	localparam logic [15:0] CORE_VEC  = 16'h7FF8;
	localparam logic [15:0] WIDE_VEC  = 16'h7FF6;
	localparam logic [15:0] LV_VEC    = 16'h7FF4;
	// ---------------------------------------------------------------
	// Legal opcode fetch windows
	// ---------------------------------------------------------------
	localparam logic [15:0] RAM_LO = 16'h0050;
	localparam logic [15:0] RAM_HI = 16'h01CF;
	localparam logic [15:0] EE_LO  = 16'h0200;
	localparam logic [15:0] EE_HI  = 16'h02FF;
	localparam logic [15:0] ROM_LO = 16'h4F00;
	localparam logic [15:0] ROM_HI = 16'h7FFF;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_NS        = 10;
	localparam int SETTLE_NS     = 40960;
	localparam int SETTLE_CYC    = SETTLE_NS / CLK_NS;
	localparam int INT_RST_NS    = 40;
	localparam int INT_RST_CYC   = (INT_RST_NS + CLK_NS - 1) / CLK_NS;
	// ---------------------------------------------------------------
	// Register map and fields
	// ---------------------------------------------------------------
	localparam logic [3:0] ADR_SOPT   = 4'h0;
	localparam logic [3:0] ADR_CCSR   = 4'h1;
	localparam logic [3:0] ADR_CCNT   = 4'h2;
	localparam logic [3:0] ADR_WIDEEN = 4'h3;
	localparam logic [3:0] ADR_KEYPAD = 4'h4;
	localparam logic [3:0] ADR_STATUS = 4'h5;
	localparam int SOPT_LEVEL = 3;
	localparam int SOPT_LVE   = 1;
	localparam int SOPT_LVF   = 0;
	localparam int CCSR_WRAPF = 7;
	localparam int CCSR_TICKF = 6;
	localparam int CCSR_WRAPE = 5;
	localparam int CCSR_TICKE = 4;
	localparam int KEY_EN     = 1;
	localparam int KEY_F      = 0;
	localparam int WIDE_N     = 7;
	localparam logic [3:0] CAUSE_POR  = 4'h1;
	localparam logic [3:0] CAUSE_PIN  = 4'h2;
	localparam logic [3:0] CAUSE_ILL  = 4'h4;
	localparam logic [3:0] CAUSE_WDOG = 4'h8;
	localparam logic [7:0] CNT_TOP    = 8'hFF;

	typedef enum {RS_SETTLE, RS_HOLD_PIN, RS_INTERNAL, RS_RUN} ric_rst_state_t;
endpackage

// *** verilog/ric_reset_seq.sv ***
`timescale 1ns/1ps
module ric_reset_seq import ric_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter bit WDOG_PRESENT  = 1'b1
) (
	// Clock and reset
	input  logic       ref_clk,
	input  logic       sys_rst,
	// Reset sources
	input  logic       rst_pin_i,
	input  logic       lv_detect,
	input  logic       illegal_fetch,
	input  logic       wdog_timeout,
	// Reset results
	output logic       core_rst,
	output logic       clr_enables,
	output logic       rst_pin_o,
	output logic       rst_pin_oe_n,
	output logic [3:0] cause_reg
);
	ric_rst_state_t state_reg;
	logic [15:0]    cnt_reg;
	logic           int_req;

	assign int_req = illegal_fetch | (WDOG_PRESENT & wdog_timeout);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= RS_SETTLE;
			cnt_reg   <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			case (state_reg)
				RS_SETTLE: begin
					if (cnt_reg == 16'(SETTLE_CYCLES - 1)) begin
						state_reg <= rst_pin_i ? RS_RUN : RS_HOLD_PIN;
					end
				end
				RS_HOLD_PIN: begin
					if (rst_pin_i) begin
						state_reg <= RS_RUN;
					end
				end
				RS_INTERNAL: begin
					if (!rst_pin_i) begin
						state_reg <= RS_HOLD_PIN;
					end else if (cnt_reg == 16'(INT_RST_CYC - 1)) begin
						state_reg <= RS_RUN;
					end
				end
				RS_RUN: begin
					if (!rst_pin_i) begin
						state_reg <= RS_HOLD_PIN;
					end else if (int_req) begin
						state_reg <= RS_INTERNAL;
						cnt_reg   <= 16'h0000;
					end
				end
				default: state_reg <= RS_SETTLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cause_reg <= CAUSE_POR;
		end else if (state_reg != RS_SETTLE && !rst_pin_i) begin
			cause_reg <= CAUSE_PIN;
		end else if (state_reg == RS_RUN && int_req) begin
			cause_reg <= illegal_fetch ? CAUSE_ILL : CAUSE_WDOG;
		end
	end

	assign core_rst     = (state_reg != RS_RUN);
	assign clr_enables  = (state_reg == RS_SETTLE) || (state_reg == RS_HOLD_PIN);
	assign rst_pin_o    = 1'b0;
	assign rst_pin_oe_n = !lv_detect;

	property p_lv_drive;
		@(posedge ref_clk) disable iff (sys_rst)
		lv_detect |-> !rst_pin_oe_n && !rst_pin_o;
	endproperty
	a_lv_drive: assert property (p_lv_drive) else $error("reset pin not driven low");

	property p_pin_release;
		@(posedge ref_clk) disable iff (sys_rst)
		state_reg == RS_HOLD_PIN && rst_pin_i |=> !core_rst;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("late resume");
endmodule

// *** verilog/ric_irq_prio.sv ***
`timescale 1ns/1ps
module ric_irq_prio import ric_pkg::*; (
	// Pending requests
	input  logic        ext_req,
	input  logic        core_req,
	input  logic        wide_req,
	input  logic        lv_req,
	// Winner
	output logic        hw_any,
	output logic [15:0] hw_vec
);
	assign hw_any = ext_req | core_req | wide_req | lv_req;

	// Descending vector address order
	always_comb begin
		if (ext_req) begin
			hw_vec = EXT_VEC;
		end else if (core_req) begin
			hw_vec = CORE_VEC;
		end else if (wide_req) begin
			hw_vec = WIDE_VEC;
		end else begin
			hw_vec = LV_VEC;
		end
	end
endmodule

// *** verilog/ric_top.sv ***
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module ric_top import ric_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter bit WDOG_PRESENT  = 1'b1
) (
	// Clock and reset
	input  logic              ref_clk,
	input  logic              sys_rst,
	// Register port
	input  logic [3:0]        reg_addr,
	input  logic [7:0]        reg_wdata,
	input  logic              reg_wr,
	input  logic              reg_rd,
	output logic [7:0]        reg_rdata,
	// Reset pin and sources
	input  logic              rst_pin_i,
	output logic              rst_pin_o,
	output logic              rst_pin_oe_n,
	input  logic              lv_detect,
	input  logic              wdog_timeout,
	// Processor core
	input  logic              opcode_fetch,
	input  logic [15:0]       fetch_addr,
	input  logic              instr_done,
	input  logic              trap_fetch,
	input  logic              ret_exec,
	input  logic              stacked_mask,
	input  logic              mask_set,
	input  logic              mask_clr,
	output logic              core_rst,
	output logic              take_irq,
	output logic              stack_pop,
	output logic [15:0]       vector_addr,
	output logic              mask_bit,
	// Peripheral requests
	input  logic              irq_pin_n,
	input  logic [7:0]        port_a_in,
	input  logic [7:0]        port_a_dir,
	input  logic              core_tick,
	input  logic              periodic_event,
	input  logic [WIDE_N-1:0] wide_flags,
	input  logic              lv_event
);
	logic              clr_enables;
	logic [3:0]        cause;
	logic              illegal_fetch;
	logic              ext_req;
	logic              ext_vec_req;
	logic              core_req;
	logic              wide_req;
	logic              lv_req;
	logic              kb_req;
	logic              hw_any;
	logic [15:0]       hw_vec;
	logic              serve_hw;
	logic              serve_trap;
	logic              serve_ext;
	logic              pin_edge;
	logic              wr_sopt;
	logic              wr_ccsr;
	logic              wr_key;
	logic [7:0]        sopt_reg;
	logic [7:0]        ccsr_reg;
	logic [7:0]        ccnt_reg;
	logic [WIDE_N-1:0] wide_en_reg;
	logic [7:0]        key_reg;
	logic              irq_prev_reg;
	logic              ext_latch_reg;
	logic              trap_pend_reg;
	logic              hw_before_trap_reg;
	logic              mask_reg;
	logic              take_reg;
	logic              pop_reg;
	logic [15:0]       vector_reg;
	logic [7:0]        rdata_reg;

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	assign illegal_fetch = opcode_fetch && !core_rst &&
		!((fetch_addr >= RAM_LO && fetch_addr <= RAM_HI) ||
		  (fetch_addr >= EE_LO && fetch_addr <= EE_HI) ||
		  (fetch_addr >= ROM_LO && fetch_addr <= ROM_HI));

	ric_reset_seq #(
		.SETTLE_CYCLES (SETTLE_CYCLES),
		.WDOG_PRESENT  (WDOG_PRESENT)
	) u_reset (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.rst_pin_i     (rst_pin_i),
		.lv_detect     (lv_detect),
		.illegal_fetch (illegal_fetch),
		.wdog_timeout  (wdog_timeout),
		.core_rst      (core_rst),
		.clr_enables   (clr_enables),
		.rst_pin_o     (rst_pin_o),
		.rst_pin_oe_n  (rst_pin_oe_n),
		.cause_reg     (cause)
	);

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	assign wr_sopt = reg_wr && reg_addr == ADR_SOPT;
	assign wr_ccsr = reg_wr && reg_addr == ADR_CCSR;
	assign wr_key  = reg_wr && reg_addr == ADR_KEYPAD;

	// Options: sensitivity select, undervoltage enable and flag
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sopt_reg <= 8'h00;
		end else begin
			if (wr_sopt) begin
				sopt_reg[SOPT_LEVEL] <= reg_wdata[SOPT_LEVEL];
				sopt_reg[SOPT_LVE]   <= reg_wdata[SOPT_LVE];
			end
			if (clr_enables) begin
				sopt_reg[SOPT_LVE] <= 1'b0;
			end
			if (core_rst) begin
				sopt_reg[SOPT_LVF] <= 1'b0;
			end else if (lv_event) begin
				sopt_reg[SOPT_LVF] <= 1'b1;
			end else if (wr_sopt && reg_wdata[SOPT_LVF]) begin
				sopt_reg[SOPT_LVF] <= 1'b0;
			end
		end
	end

	// Core counter and its control/status
	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			ccnt_reg <= 8'h00;
		end else if (core_tick) begin
			ccnt_reg <= ccnt_reg + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ccsr_reg <= 8'h00;
		end else begin
			if (wr_ccsr) begin
				ccsr_reg[CCSR_WRAPE] <= reg_wdata[CCSR_WRAPE];
				ccsr_reg[CCSR_TICKE] <= reg_wdata[CCSR_TICKE];
			end
			if (clr_enables) begin
				ccsr_reg[CCSR_WRAPE] <= 1'b0;
				ccsr_reg[CCSR_TICKE] <= 1'b0;
			end
			if (core_rst) begin
				ccsr_reg[CCSR_WRAPF] <= 1'b0;
			end else if (core_tick && ccnt_reg == CNT_TOP) begin
				ccsr_reg[CCSR_WRAPF] <= 1'b1;
			end else if (wr_ccsr && reg_wdata[CCSR_WRAPF]) begin
				ccsr_reg[CCSR_WRAPF] <= 1'b0;
			end
			if (core_rst) begin
				ccsr_reg[CCSR_TICKF] <= 1'b0;
			end else if (periodic_event) begin
				ccsr_reg[CCSR_TICKF] <= 1'b1;
			end else if (wr_ccsr && reg_wdata[CCSR_TICKF]) begin
				ccsr_reg[CCSR_TICKF] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || clr_enables) begin
			wide_en_reg <= '0;
		end else if (reg_wr && reg_addr == ADR_WIDEEN) begin
			wide_en_reg <= reg_wdata[WIDE_N-1:0];
		end
	end

	// Keypad enable and flag
	assign kb_req = |(~port_a_in & ~port_a_dir);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			key_reg <= 8'h00;
		end else begin
			if (wr_key) begin
				key_reg[KEY_EN] <= reg_wdata[KEY_EN];
			end
			if (clr_enables) begin
				key_reg[KEY_EN] <= 1'b0;
			end
			if (core_rst) begin
				key_reg[KEY_F] <= 1'b0;
			end else if (kb_req) begin
				key_reg[KEY_F] <= 1'b1;
			end else if (wr_key && reg_wdata[KEY_F]) begin
				key_reg[KEY_F] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// External pin latch
	// ---------------------------------------------------------------
	assign pin_edge = irq_prev_reg && !irq_pin_n;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_prev_reg <= 1'b1;
		end else begin
			irq_prev_reg <= irq_pin_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			ext_latch_reg <= 1'b0;
		end else if (pin_edge) begin
			ext_latch_reg <= 1'b1;
		end else if (serve_ext) begin
			ext_latch_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Request gathering and priority
	// ---------------------------------------------------------------
	assign ext_req = ext_latch_reg || (sopt_reg[SOPT_LEVEL] && !irq_pin_n);
	assign ext_vec_req = ext_req || (key_reg[KEY_F] && key_reg[KEY_EN]);
	assign core_req = (ccsr_reg[CCSR_WRAPF] && ccsr_reg[CCSR_WRAPE]) ||
		(ccsr_reg[CCSR_TICKF] && ccsr_reg[CCSR_TICKE]);
	assign wide_req = |(wide_flags & wide_en_reg);
	assign lv_req = sopt_reg[SOPT_LVF] && sopt_reg[SOPT_LVE];

	ric_irq_prio u_prio (
		.ext_req  (ext_vec_req),
		.core_req (core_req),
		.wide_req (wide_req),
		.lv_req   (lv_req),
		.hw_any   (hw_any),
		.hw_vec   (hw_vec)
	);

	// ---------------------------------------------------------------
	// Service decision at instruction end
	// ---------------------------------------------------------------
	assign serve_hw = instr_done && !core_rst && hw_any && !mask_reg &&
		(!trap_pend_reg || hw_before_trap_reg);
	assign serve_trap = instr_done && !core_rst && trap_pend_reg && !serve_hw;
	assign serve_ext = serve_hw && hw_vec == EXT_VEC;

	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			trap_pend_reg      <= 1'b0;
			hw_before_trap_reg <= 1'b0;
		end else if (trap_fetch) begin
			trap_pend_reg      <= 1'b1;
			hw_before_trap_reg <= hw_any && !mask_reg;
		end else begin
			if (serve_trap) begin
				trap_pend_reg <= 1'b0;
			end
			if (serve_hw) begin
				hw_before_trap_reg <= 1'b0;
			end
		end
	end

	// Mask bit: reset, take, return, then explicit set/clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			mask_reg <= 1'b1;
		end else if (serve_hw || serve_trap) begin
			mask_reg <= 1'b1;
		end else if (ret_exec) begin
			mask_reg <= stacked_mask;
		end else if (mask_set) begin
			mask_reg <= 1'b1;
		end else if (mask_clr) begin
			mask_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			vector_reg <= RESET_VEC;
		end else if (serve_hw) begin
			vector_reg <= hw_vec;
		end else if (serve_trap) begin
			vector_reg <= TRAP_VEC;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || core_rst) begin
			take_reg <= 1'b0;
			pop_reg  <= 1'b0;
		end else begin
			take_reg <= serve_hw || serve_trap;
			pop_reg  <= ret_exec && !(serve_hw || serve_trap);
		end
	end

	assign take_irq    = take_reg;
	assign stack_pop   = pop_reg;
	assign vector_addr = vector_reg;
	assign mask_bit    = mask_reg;

	// ---------------------------------------------------------------
	// Register reads
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADR_SOPT:   rdata_reg <= sopt_reg;
				ADR_CCSR:   rdata_reg <= ccsr_reg;
				ADR_CCNT:   rdata_reg <= ccnt_reg;
				ADR_WIDEEN: rdata_reg <= {1'b0, wide_en_reg};
				ADR_KEYPAD: rdata_reg <= key_reg;
				ADR_STATUS: rdata_reg <= {cause, 1'b0, ext_latch_reg, trap_pend_reg, mask_reg};
				default:    rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata = rdata_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_reset_vec;
		@(posedge ref_clk) disable iff (sys_rst)
		core_rst |=> vector_addr == RESET_VEC && mask_bit;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector or mask wrong");

	property p_take_mask;
		@(posedge ref_clk) disable iff (sys_rst)
		serve_hw || serve_trap |=> take_irq && mask_bit;
	endproperty
	a_take_mask: assert property (p_take_mask) else $error("take without mask set");

	property p_ret;
		@(posedge ref_clk) disable iff (sys_rst)
		ret_exec && !core_rst && !serve_hw && !serve_trap |=>
			stack_pop && mask_bit == $past(stacked_mask);
	endproperty
	a_ret: assert property (p_ret) else $error("mask not restored");

	property p_masked;
		@(posedge ref_clk) disable iff (sys_rst)
		take_irq && vector_addr != TRAP_VEC |-> $past(instr_done) && !$past(mask_reg);
	endproperty
	a_masked: assert property (p_masked) else $error("hardware take while masked");

	property p_clr_en;
		@(posedge ref_clk) disable iff (sys_rst)
		clr_enables |=> wide_en_reg == '0 && !key_reg[KEY_EN] && !sopt_reg[SOPT_LVE];
	endproperty
	a_clr_en: assert property (p_clr_en) else $error("enables survive reset");

	property p_prio;
		@(posedge ref_clk) disable iff (sys_rst)
		serve_hw && ext_vec_req |=> vector_addr == EXT_VEC;
	endproperty
	a_prio: assert property (p_prio) else $error("external lost priority");

	property p_ext_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		serve_ext && !pin_edge |=> !ext_latch_reg;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("latch not cleared");

	property p_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		!core_rst && core_tick && ccnt_reg == CNT_TOP |=> ccsr_reg[CCSR_WRAPF] && ccnt_reg == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag missed");

	property p_illegal;
		@(posedge ref_clk) disable iff (sys_rst)
		illegal_fetch |=> core_rst [*2];
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal fetch no reset");
endmodule

// *** sim/ric_core_model.sv ***
`timescale 1ns/1ps
module ric_core_model (
	// Clock
	input  logic        ref_clk,
	// Core strobes
	output logic        opcode_fetch,
	output logic [15:0] fetch_addr,
	output logic        instr_done,
	output logic        trap_fetch,
	output logic        ret_exec,
	output logic        stacked_mask,
	output logic        mask_set,
	output logic        mask_clr
);
	initial begin
		{opcode_fetch, instr_done, trap_fetch, ret_exec, mask_set, mask_clr} = 6'h00;
		fetch_addr   = 16'h4F00;
		stacked_mask = 1'b1;
	end
	// Instruction end strobe; instr_done high for one clock, no trap fetch driven
	task automatic instr();
		@(posedge ref_clk) instr_done <= 1'b1;
		@(posedge ref_clk) instr_done <= 1'b0;
		#1;
	endtask
	// Address is scrambled once the fetch is over
	task automatic fetch(input logic [15:0] a);
		@(posedge ref_clk) opcode_fetch <= 1'b1;
		fetch_addr <= a;
		@(posedge ref_clk) opcode_fetch <= 1'b0;
		fetch_addr <= ~a;
	endtask
	task automatic trap();
		@(posedge ref_clk) trap_fetch <= 1'b1;
		@(posedge ref_clk) trap_fetch <= 1'b0;
	endtask
	task automatic ret(input logic m);
		@(posedge ref_clk) ret_exec <= 1'b1;
		stacked_mask <= m;
		@(posedge ref_clk) ret_exec <= 1'b0;
		stacked_mask <= ~m;
		#1;
	endtask
	task automatic mset();
		@(posedge ref_clk) mask_set <= 1'b1;
		@(posedge ref_clk) mask_set <= 1'b0;
		#1;
	endtask
	task automatic mclr();
		@(posedge ref_clk) mask_clr <= 1'b1;
		@(posedge ref_clk) mask_clr <= 1'b0;
	endtask
endmodule

// *** sim/reset_and_interrupt_control_tb.sv ***
`timescale 1ns/1ps
module reset_and_interrupt_control_tb import ric_pkg::*;;
	localparam int SC = 8;
	logic              ref_clk, sys_rst, reg_wr, reg_rd, tb_pin, lv_detect, wdog_timeout;
	logic [3:0]        reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, d, port_a_in, port_a_dir;
	logic              rst_pin_i, rst_pin_o, rst_pin_oe_n, core_rst, take_irq, stack_pop;
	logic              mask_bit, irq_pin_n, core_tick, periodic_event, lv_event;
	logic              opcode_fetch, instr_done, trap_fetch, ret_exec, stacked_mask;
	logic              mask_set, mask_clr;
	logic [15:0]       fetch_addr, vector_addr;
	logic [WIDE_N-1:0] wide_flags;
	int                n_mismatch, checks_done;

	// Pin level: driven low by the block, else by the bench
	assign rst_pin_i = rst_pin_oe_n ? tb_pin : rst_pin_o;

	always #5 ref_clk = ~ref_clk;

	ric_core_model core (.ref_clk(ref_clk), .opcode_fetch(opcode_fetch),
		.fetch_addr(fetch_addr), .instr_done(instr_done), .trap_fetch(trap_fetch),
		.ret_exec(ret_exec), .stacked_mask(stacked_mask), .mask_set(mask_set),
		.mask_clr(mask_clr));

	ric_top #(.SETTLE_CYCLES(SC), .WDOG_PRESENT(1'b1)) uut (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_i(rst_pin_i),
		.rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .lv_detect(lv_detect),
		.wdog_timeout(wdog_timeout), .opcode_fetch(opcode_fetch), .fetch_addr(fetch_addr),
		.instr_done(instr_done), .trap_fetch(trap_fetch), .ret_exec(ret_exec),
		.stacked_mask(stacked_mask), .mask_set(mask_set), .mask_clr(mask_clr),
		.core_rst(core_rst), .take_irq(take_irq), .stack_pop(stack_pop),
		.vector_addr(vector_addr), .mask_bit(mask_bit), .irq_pin_n(irq_pin_n),
		.port_a_in(port_a_in), .port_a_dir(port_a_dir), .core_tick(core_tick),
		.periodic_event(periodic_event), .wide_flags(wide_flags), .lv_event(lv_event));

	// ---------------------------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk) reg_wr <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk) reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic pulse_wait(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic tk(input logic [15:0] v);
		core.instr();
		chk(16'(take_irq), 16'h1, "no take");
		chk(vector_addr, v, "vector");
		chk(16'(mask_bit), 16'h1, "mask after take");
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{ref_clk, reg_wr, reg_rd, tb_pin, lv_detect, wdog_timeout} = 6'h00;
		{core_tick, periodic_event, lv_event} = 3'h0;
		sys_rst    = 1'b1;
		irq_pin_n  = 1'b1;
		reg_addr   = 4'h0;
		reg_wdata  = 8'h00;
		port_a_in  = 8'hFF;
		port_a_dir = 8'h00;
		wide_flags = '0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		pulse_wait(1);
		chk(vector_addr, RESET_VEC, "reset vector");
		chk(16'(mask_bit), 16'h1, "reset mask");
		pulse_wait(SC + 4);
		chk(16'(core_rst), 16'h1, "released with pin low");
		@(posedge ref_clk) tb_pin <= 1'b1;
		pulse_wait(2);
		chk(16'(core_rst), 16'h0, "not resumed");
		rd(4'hF);
		chk(16'(d), 16'h0, "unmapped read");
		rd(ADR_CCSR);
		chk(16'(d), 16'h0, "core enables after reset");
		rd(ADR_WIDEEN);
		chk(16'(d), 16'h0, "wide enables after reset");
		tend("reset");

		wr(ADR_CCSR, 8'h10);
		@(posedge ref_clk) periodic_event <= 1'b1;
		irq_pin_n <= 1'b0;
		@(posedge ref_clk) periodic_event <= 1'b0;
		core.mclr();
		tk(EXT_VEC);
		core.ret(1'b0);
		chk(16'(stack_pop), 16'h1, "no pop");
		chk(16'(mask_bit), 16'h0, "mask not restored");
		tk(CORE_VEC);
		irq_pin_n <= 1'b1;
		wr(ADR_CCSR, 8'h40);
		wr(ADR_WIDEEN, 8'h40);
		wide_flags <= 7'h40;
		core.instr();
		chk(16'(take_irq), 16'h0, "taken while masked");
		core.ret(1'b0);
		tk(WIDE_VEC);
		wide_flags <= '0;
		core.trap();
		tk(TRAP_VEC);
		wr(ADR_SOPT, 8'h02);
		@(posedge ref_clk) lv_event <= 1'b1;
		@(posedge ref_clk) lv_event <= 1'b0;
		core.mclr();
		tk(LV_VEC);
		wr(ADR_SOPT, 8'h01);
		tend("priority");

		wr(ADR_KEYPAD, 8'h02);
		port_a_dir <= 8'h01;
		port_a_in  <= 8'hFE;
		core.mclr();
		core.instr();
		chk(16'(take_irq), 16'h0, "output line requested");
		port_a_dir <= 8'h00;
		tk(EXT_VEC);
		port_a_in <= 8'hFF;
		rd(ADR_KEYPAD);
		chk(16'(d[KEY_F]), 16'h1, "keypad flag lost");
		wr(ADR_KEYPAD, 8'h03);
		rd(ADR_KEYPAD);
		chk(16'(d), 16'h2, "keypad flag not cleared");
		wr(ADR_SOPT, 8'h08);
		irq_pin_n <= 1'b0;
		core.mclr();
		tk(EXT_VEC);
		core.ret(1'b0);
		tk(EXT_VEC);
		irq_pin_n <= 1'b1;
		wr(ADR_SOPT, 8'h00);
		core.mclr();
		core.mset();
		chk(16'(mask_bit), 16'h1, "mask set lost");
		tend("keypad and level");

		wr(ADR_CCSR, 8'h20);
		@(posedge ref_clk) core_tick <= 1'b1;
		repeat (255) @(posedge ref_clk);
		core_tick <= 1'b0;
		rd(ADR_CCNT);
		chk(16'(d), 16'h00FF, "count before wrap");
		rd(ADR_CCSR);
		chk(16'(d[7]), 16'h0, "wrap too early");
		@(posedge ref_clk) core_tick <= 1'b1;
		@(posedge ref_clk) core_tick <= 1'b0;
		rd(ADR_CCSR);
		chk(16'(d[7]), 16'h1, "no wrap flag");
		core.mclr();
		tk(CORE_VEC);
		wr(ADR_CCSR, 8'hB0);
		tend("core counter");

		core.fetch(16'h01CF);
		pulse_wait(1);
		chk(16'(core_rst), 16'h0, "legal fetch reset");
		core.fetch(16'h01D0);
		pulse_wait(1);
		chk(16'(core_rst), 16'h1, "illegal fetch kept running");
		chk(vector_addr, RESET_VEC, "illegal reset vector");
		pulse_wait(8);
		chk(16'(core_rst), 16'h0, "internal reset stuck");
		rd(ADR_CCSR);
		chk(16'(d[5:4]), 16'h3, "enables lost");
		@(posedge ref_clk) wdog_timeout <= 1'b1;
		@(posedge ref_clk) wdog_timeout <= 1'b0;
		pulse_wait(1);
		chk(16'(core_rst), 16'h1, "no watchdog reset");
		pulse_wait(8);
		rd(ADR_STATUS);
		chk(16'(d[7]), 16'h1, "watchdog cause");
		@(posedge ref_clk) lv_detect <= 1'b1;
		pulse_wait(2);
		chk(16'(rst_pin_oe_n), 16'h0, "pin not driven");
		chk(16'(rst_pin_o), 16'h0, "pin driven high");
		chk(16'(core_rst), 16'h1, "no low voltage reset");
		@(posedge ref_clk) lv_detect <= 1'b0;
		@(posedge ref_clk) tb_pin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		tb_pin <= 1'b1;
		pulse_wait(3);
		rd(ADR_CCSR);
		chk(16'(d[5:4]), 16'h0, "pin reset kept enables");
		rd(ADR_STATUS);
		chk(16'(d[7:4]), 16'(CAUSE_PIN), "pin cause");
		tend("reset sources");
		print_verdict();
	end
endmodule
